/* File: spt_pkg.sv */
package spt_pkg;

  // ==========================================================
  // Register map (byte addresses, 16-bit registers)
  localparam logic [15:0] ADDR_COUNT = 16'h0100;
  localparam logic [15:0] ADDR_PERIOD = 16'h0102;
  localparam logic [15:0] ADDR_CONTROL = 16'h0104;
  localparam logic [15:0] ADDR_IRQ_STATUS = 16'h0106;
  localparam logic [15:0] ADDR_IRQ_MASK = 16'h0108;

  // ==========================================================
  // Reset values
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [15:0] PERIOD_RESET = 16'hFFFF;
  localparam logic [15:0] CONTROL_RESET = 16'h0000;
  localparam logic [15:0] DATA_ZERO = 16'h0000;

  // ==========================================================
  // Control register bit positions
  localparam int CTL_TIMER_ON = 15;
  localparam int CTL_IDLE_STOP = 13;
  localparam int CTL_GATE_EN = 6;
  localparam int CTL_PRESC_HI = 5;
  localparam int CTL_PRESC_LO = 4;
  localparam int CTL_EXT_SYNC = 2;
  localparam int CTL_CLK_SRC = 1;

  // Interrupt status / mask bit
  localparam int IRQ_PERIOD_BIT = 0;

  // ==========================================================
  // Prescaler
  localparam int PRESC_W = 8;
  localparam logic [1:0] PRESC_SEL_1 = 2'h0;
  localparam logic [1:0] PRESC_SEL_8 = 2'h1;
  localparam logic [1:0] PRESC_SEL_64 = 2'h2;
  localparam logic [7:0] PRESC_LAST_1 = 8'h00;
  localparam logic [7:0] PRESC_LAST_8 = 8'h07;
  localparam logic [7:0] PRESC_LAST_64 = 8'h3F;
  localparam logic [7:0] PRESC_LAST_256 = 8'hFF;

  // Instruction cycle is the core clock divided by four
  localparam int INST_DIV = 4;

  // ==========================================================
  // Decoded control fields
  typedef struct packed {
    logic timer_on_bit;
    logic idle_stop_bit;
    logic gate_accumulate_enable;
    logic [1:0] prescale_select;
    logic external_sync_select;
    logic clock_source_select;
  } spt_ctrl_t;

  // Register bus request
  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } spt_bus_req_t;

endpackage

/* File: spt_timer.sv */
`timescale 1ns/1ps

// Functional notes
// - In timer mode the count rises once per instruction cycle and, once equal to the period, loads zero.
// - The internal source is the core clock divided by four, the external source is the pin, both via the prescaler.
// - In synchronous counter mode pin rising edges are aligned to the instruction phase before counting.
// - In asynchronous counter mode every rising pin edge counts, wrapping to zero after the period value.
// - In timer, synchronous and gated modes an idle-stop bit of one freezes the count during Idle.
// - In asynchronous counter mode the count also stops during Idle when the idle-stop bit is one.
// - Gated mode counts instruction cycles only while the pin is high, needing gate enable, timer on and internal source.
// - The prescaler divides the selected source by 1, 8, 64 or 256 from the two-bit prescale field.
// - The prescaler counter clears on a count write, a control write and reset.
// - With the timer off the prescaler is halted and writes do not clear it.
// - A control write leaves the count untouched; only a count write or a tick changes it.
// - A period match raises an interrupt request, and so does a gate falling edge in gated mode.
// - The sync-select bit at zero makes the external path asynchronous, at one synchronised.
// - In Sleep the timer runs only when on, externally clocked and asynchronous.
// - A period match sets a sticky flag that only software clears, gated onto the interrupt by its enable.
// - In gated mode the gate falling edge that ends accumulation also sets the flag.
module spt_timer #(
  parameter int INST_DIV = spt_pkg::INST_DIV
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [15:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic external_clock_gate_pin,
  input wire logic cpu_idle,
  input wire logic cpu_sleep,
  output logic irq
);

  // ==========================================================
  // Register bus decode
  spt_pkg::spt_bus_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  wire logic wr_count = req.wr && (req.addr == spt_pkg::ADDR_COUNT);
  wire logic wr_period = req.wr && (req.addr == spt_pkg::ADDR_PERIOD);
  wire logic wr_control = req.wr && (req.addr == spt_pkg::ADDR_CONTROL);
  wire logic wr_status = req.wr && (req.addr == spt_pkg::ADDR_IRQ_STATUS);
  wire logic wr_mask = req.wr && (req.addr == spt_pkg::ADDR_IRQ_MASK);

  logic [15:0] count_r;
  logic [15:0] period_r;
  logic [15:0] control_r;
  logic status_r;
  logic mask_r;
  logic [15:0] rdata_r;

  spt_pkg::spt_ctrl_t ctl;
  assign ctl = '{
    timer_on_bit: control_r[spt_pkg::CTL_TIMER_ON],
    idle_stop_bit: control_r[spt_pkg::CTL_IDLE_STOP],
    gate_accumulate_enable: control_r[spt_pkg::CTL_GATE_EN],
    prescale_select: control_r[spt_pkg::CTL_PRESC_HI:spt_pkg::CTL_PRESC_LO],
    external_sync_select: control_r[spt_pkg::CTL_EXT_SYNC],
    clock_source_select: control_r[spt_pkg::CTL_CLK_SRC]
  };

  // Unimplemented control bits are dropped so they read as zero
  wire logic [15:0] control_mask = (16'h0001 << spt_pkg::CTL_TIMER_ON) | (16'h0001 << spt_pkg::CTL_IDLE_STOP)
    | (16'h0001 << spt_pkg::CTL_GATE_EN) | (16'h0001 << spt_pkg::CTL_PRESC_HI)
    | (16'h0001 << spt_pkg::CTL_PRESC_LO) | (16'h0001 << spt_pkg::CTL_EXT_SYNC)
    | (16'h0001 << spt_pkg::CTL_CLK_SRC);

  // ==========================================================
  // Pin synchroniser; first stage feeds only the second
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= external_clock_gate_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  wire logic pin_rise = pin_sync_r && !pin_prev_r;
  wire logic pin_fall = !pin_sync_r && pin_prev_r;

  // ==========================================================
  // Instruction cycle divider
  localparam int DIV_W = $clog2(INST_DIV);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INST_DIV - 1);
  logic [DIV_W-1:0] div_r;
  wire logic inst_tick = (div_r == DIV_LAST);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      div_r <= '0;
    end else begin
      div_r <= inst_tick ? '0 : div_r + 1'b1;
    end
  end

  // ==========================================================
  // Source selection
  wire logic gated_mode = ctl.gate_accumulate_enable && !ctl.clock_source_select;
  wire logic async_mode = ctl.clock_source_select && !ctl.external_sync_select;
  wire logic sync_mode = ctl.clock_source_select && ctl.external_sync_select;

  // Pending edge waits for the next instruction phase
  logic edge_pend_r;
  wire logic sync_edge = (edge_pend_r || pin_rise) && inst_tick;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      edge_pend_r <= 1'b0;
    end else begin
      edge_pend_r <= (edge_pend_r || pin_rise) && !inst_tick;
    end
  end

  wire logic gated_event = inst_tick && pin_sync_r;
  wire logic ext_event = ctl.external_sync_select ? sync_edge : pin_rise;
  wire logic src_event = ctl.clock_source_select ? ext_event : (gated_mode ? gated_event : inst_tick);

  // idle freeze; applies to the async path too
  wire logic idle_hold = cpu_idle && ctl.idle_stop_bit;
  // only the async external counter survives Sleep
  wire logic sleep_hold = cpu_sleep && !async_mode;
  wire logic run = ctl.timer_on_bit && !idle_hold && !sleep_hold;

  // ==========================================================
  // Prescaler
  logic [spt_pkg::PRESC_W-1:0] presc_r;
  // ratio encoding; divide by 1, 8, 64, 256
  wire logic [spt_pkg::PRESC_W-1:0] presc_last =
    (ctl.prescale_select == spt_pkg::PRESC_SEL_1) ? spt_pkg::PRESC_LAST_1 :
    (ctl.prescale_select == spt_pkg::PRESC_SEL_8) ? spt_pkg::PRESC_LAST_8 :
    (ctl.prescale_select == spt_pkg::PRESC_SEL_64) ? spt_pkg::PRESC_LAST_64 : spt_pkg::PRESC_LAST_256;
  wire logic presc_in = run && src_event;
  wire logic tick = presc_in && (presc_r >= presc_last);
  // clear on writes; only while the timer on bit is set
  wire logic presc_clear = ctl.timer_on_bit && (wr_count || wr_control);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_r <= '0;
    end else if (presc_clear || tick) begin
      presc_r <= '0;
    end else if (presc_in) begin
      presc_r <= presc_r + 1'b1;
    end
  end

  // ==========================================================
  // Counter
  wire logic match = tick && (count_r == period_r);
  // wrap to zero after matching the period
  wire logic [15:0] count_nxt = wr_count ? req.wdata : (match ? spt_pkg::COUNT_RESET : count_r + 16'h0001);
  // only count writes or ticks move the count
  wire logic count_load = wr_count || tick;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= spt_pkg::COUNT_RESET;
    end else if (count_load) begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      period_r <= spt_pkg::PERIOD_RESET;
      control_r <= spt_pkg::CONTROL_RESET;
      mask_r <= 1'b0;
    end else begin
      if (wr_period) begin
        period_r <= req.wdata;
      end
      if (wr_control) begin
        control_r <= req.wdata & control_mask;
      end
      if (wr_mask) begin
        mask_r <= req.wdata[spt_pkg::IRQ_PERIOD_BIT];
      end
    end
  end

  // ==========================================================
  // Interrupt flag; a set in the clearing cycle wins
  // gate falling edge ends accumulation
  wire logic gate_end = pin_fall && gated_mode && ctl.timer_on_bit;
  wire logic irq_event = match || gate_end;
  wire logic status_clr = wr_status && req.wdata[spt_pkg::IRQ_PERIOD_BIT];
  // sticky flag, cleared only by software
  wire logic status_nxt = (status_r && !status_clr) || irq_event;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      status_r <= 1'b0;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign irq = status_r && mask_r;

  // ==========================================================
  // Read data, valid only in the cycle after the strobe
  wire logic [15:0] read_mux =
    (req.addr == spt_pkg::ADDR_COUNT) ? count_r :
    (req.addr == spt_pkg::ADDR_PERIOD) ? period_r :
    (req.addr == spt_pkg::ADDR_CONTROL) ? control_r :
    (req.addr == spt_pkg::ADDR_IRQ_STATUS) ? {15'h0000, status_r} :
    (req.addr == spt_pkg::ADDR_IRQ_MASK) ? {15'h0000, mask_r} : spt_pkg::DATA_ZERO;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_r <= spt_pkg::DATA_ZERO;
    end else begin
      rdata_r <= req.rd ? read_mux : spt_pkg::DATA_ZERO;
    end
  end

  assign reg_rdata = rdata_r;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence inst_gap_s;
    !inst_tick [*3] ##1 inst_tick;
  endsequence

  inst_period_a: assert property (inst_tick |=> inst_gap_s)
    else $error("instruction tick spacing wrong");

  wrap_zero_a: assert property (tick && (count_r == period_r) && !wr_count |=> count_r == 16'h0000)
    else $error("count did not wrap to zero");

  count_step_a: assert property (tick && (count_r != period_r) && !wr_count
    |=> count_r == $past(count_r) + 16'h0001)
    else $error("count did not advance by one");

  sync_phase_a: assert property (run && sync_mode && pin_rise && !inst_tick
    |-> ##[1:3] (src_event && inst_tick))
    else $error("synchronous edge not taken on phase");

  async_edge_a: assert property (run && async_mode && pin_rise |-> src_event && presc_in)
    else $error("asynchronous edge missed");

  idle_freeze_a: assert property (cpu_idle && ctl.idle_stop_bit && !wr_count |=> $stable(count_r))
    else $error("count moved during idle stop");

  idle_async_a: assert property (cpu_idle && ctl.idle_stop_bit && async_mode |-> !presc_in)
    else $error("async counter ran during idle stop");

  gate_low_a: assert property (gated_mode && !pin_sync_r |-> !src_event)
    else $error("gated count with gate low");

  presc_ratio_a: assert property (tick |-> presc_r == presc_last)
    else $error("prescaler tick at wrong count");

  presc_clear_a: assert property (ctl.timer_on_bit && wr_control |=> presc_r == '0)
    else $error("prescaler not cleared by write");

  presc_halt_a: assert property (!ctl.timer_on_bit |=> $stable(presc_r))
    else $error("prescaler moved while timer off");

  ctrl_keep_a: assert property (wr_control && !tick |=> $stable(count_r))
    else $error("control write changed count");

  sleep_stop_a: assert property (cpu_sleep && !async_mode |-> !tick)
    else $error("timer ran in sleep");

  flag_set_a: assert property (match |=> status_r ##1 (status_r || $past(status_clr)))
    else $error("match did not set flag");

  gate_flag_a: assert property (gate_end |=> status_r)
    else $error("gate fall did not set flag");

  irq_level_a: assert property (irq == (status_r && mask_r))
    else $error("interrupt output mismatch");

  count_hold_a: assert property (!tick && !wr_count |=> $stable(count_r))
    else $error("count moved without a tick");

  div_wrap_a: assert property (inst_tick |=> div_r == '0)
    else $error("instruction divider did not restart");

  sync_early_a: assert property (sync_mode && !inst_tick |-> !src_event)
    else $error("synchronous edge taken off phase");

  sync_pend_a: assert property (sync_mode && pin_rise && !inst_tick |=> edge_pend_r)
    else $error("synchronised edge not held");

  async_only_a: assert property (async_mode && !pin_rise |-> !src_event)
    else $error("asynchronous count without a pin rise");

  idle_run_a: assert property (cpu_idle && !ctl.idle_stop_bit && ctl.timer_on_bit && !cpu_sleep
    && !ctl.clock_source_select && !ctl.gate_accumulate_enable && inst_tick |-> presc_in)
    else $error("count stopped in idle without idle stop");

  gate_high_a: assert property (gated_mode && ctl.timer_on_bit && pin_sync_r && inst_tick
    && !cpu_idle && !cpu_sleep |-> presc_in)
    else $error("gated cycle not counted");

  presc_step_a: assert property (presc_in && !tick && !presc_clear |=> presc_r == $past(presc_r) + 1'b1)
    else $error("prescaler did not step");

  presc_cnt_clr_a: assert property (ctl.timer_on_bit && wr_count |=> presc_r == '0)
    else $error("prescaler not cleared by count write");

  presc_keep_a: assert property (!ctl.timer_on_bit && (wr_count || wr_control) |=> $stable(presc_r))
    else $error("halted prescaler changed on write");

  count_write_a: assert property (wr_count |=> count_r == $past(req.wdata))
    else $error("count write not loaded");

  irq_rise_a: assert property (irq_event && mask_r && !wr_mask |=> irq)
    else $error("interrupt not raised on event");

  presc_unity_a: assert property ((ctl.prescale_select == spt_pkg::PRESC_SEL_1) && presc_in |-> tick)
    else $error("unity prescale skipped an event");

  sleep_async_a: assert property (cpu_sleep && async_mode && ctl.timer_on_bit && !idle_hold && pin_rise |-> presc_in)
    else $error("asynchronous counter stopped in sleep");

  flag_hold_a: assert property (status_r && !status_clr |=> status_r)
    else $error("flag dropped without a clear");

  flag_clear_a: assert property (status_clr && !irq_event |=> !status_r)
    else $error("flag not cleared by write");

endmodule

/* File: spt_pin_src.sv */
`timescale 1ns/1ps

// ==========================================
// External clock and gate source
module spt_pin_src (
  input wire logic core_clk,
  input wire logic go,
  input wire logic [7:0] pulses,
  input wire logic [7:0] half_len,
  output logic pin,
  output logic busy
);
  logic pin_r = 1'b0;
  logic busy_r = 1'b0;

  assign pin = pin_r;
  assign busy = busy_r;

  // Pin rests low between bursts, so a gate burst always ends on a fall
  always @(posedge core_clk) begin
    if (go && !busy_r) begin
      busy_r <= 1'b1;
      for (int p = 0; p < pulses; p++) begin
        pin_r <= 1'b1;
        repeat (half_len) @(posedge core_clk);
        pin_r <= 1'b0;
        repeat (half_len) @(posedge core_clk);
      end
      busy_r <= 1'b0;
    end
  end
endmodule

/* File: spt_timer_tb.sv */
`timescale 1ns/1ps
`define CHK(what, exp, got) begin n_compared++; if ((got) !== (exp)) begin fail_count++; \
  $display("mismatch %s expected %h seen %h", what, exp, got); end end

module spt_timer_tb;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic cpu_idle = 1'b0;
  logic cpu_sleep = 1'b0;
  logic go = 1'b0;
  logic [7:0] pulses = 8'h00;
  logic [7:0] half_len = 8'h04;
  logic [15:0] reg_rdata;
  logic pin;
  logic irq;
  logic busy;
  logic [15:0] d;
  int fail_count = 0;
  int n_compared = 0;
  int cyc = 0;
  int ta;
  int tb;
  int ratio[4] = '{1, 8, 64, 256};
  logic [15:0] ra[5] = '{16'h0100, 16'h0102, 16'h0104, 16'h0106, 16'h0108};
  logic [15:0] ev[5] = '{spt_pkg::COUNT_RESET, spt_pkg::PERIOD_RESET, spt_pkg::CONTROL_RESET, 16'h0000, 16'h0000};

  always #10 core_clk = ~core_clk;
  always @(posedge core_clk) cyc <= cyc + 1;

  spt_timer spt_timer_inst (
    .core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .external_clock_gate_pin(pin),
    .cpu_idle(cpu_idle), .cpu_sleep(cpu_sleep), .irq(irq)
  );

  spt_pin_src spt_pin_src_inst (
    .core_clk(core_clk), .go(go), .pulses(pulses), .half_len(half_len), .pin(pin), .busy(busy)
  );

  // ==========================================
  // Bus and wait tasks
  task automatic tally_and_finish();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic hang();
    fail_count++;
    $display("mismatch wait expected done seen timeout");
    tally_and_finish();
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] a, output logic [15:0] v);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    v = reg_rdata;
    // Return on a rising edge so the caller drives there
    @(posedge core_clk);
  endtask

  // Falling-edge sampling lets the wrap edge settle first
  task automatic wait_irq(output int t);
    int k;
    k = 0;
    @(negedge core_clk);
    while (irq !== 1'b1) begin
      if (k == 3000) begin
        hang();
      end
      k++;
      @(negedge core_clk);
    end
    t = cyc;
  endtask

  // Reads 40 cycles apart span exactly ten instruction ticks
  task automatic span(output logic [15:0] delta);
    logic [15:0] first;
    rd(spt_pkg::ADDR_COUNT, first);
    repeat (37) @(posedge core_clk);
    rd(spt_pkg::ADDR_COUNT, delta);
    delta = delta - first;
  endtask

  task automatic burst(input logic [15:0] ctl, input logic [7:0] n, input logic [7:0] h);
    int k;
    wr(spt_pkg::ADDR_CONTROL, ctl);
    wr(spt_pkg::ADDR_COUNT, 16'h0000);
    @(posedge core_clk);
    go <= 1'b1;
    pulses <= n;
    half_len <= h;
    @(posedge core_clk);
    go <= 1'b0;
    @(posedge core_clk);
    k = 0;
    while (busy !== 1'b0) begin
      if (k == 3000) begin
        hang();
      end
      k++;
      @(posedge core_clk);
    end
    // Margin for the pin synchroniser and edge flop
    repeat (6) @(posedge core_clk);
    rd(spt_pkg::ADDR_COUNT, d);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    repeat (5) @(posedge core_clk);
    `CHK("irq in reset", 1'b0, irq)
    reset_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], d);
      `CHK("reset value", ev[i], d)
    end
    wr(16'h0110, 16'hFFFF);
    rd(16'h0110, d);
    `CHK("unmapped read", 16'h0000, d)
    wr(spt_pkg::ADDR_CONTROL, 16'hFFFF);
    rd(spt_pkg::ADDR_CONTROL, d);
    `CHK("control bits", 16'hA076, d)
    wr(spt_pkg::ADDR_CONTROL, 16'h0000);
    wr(spt_pkg::ADDR_COUNT, 16'h1234);
    wr(spt_pkg::ADDR_CONTROL, 16'h0030);
    rd(spt_pkg::ADDR_COUNT, d);
    `CHK("count kept", 16'h1234, d)
    wr(spt_pkg::ADDR_PERIOD, 16'h0001);
    wr(spt_pkg::ADDR_COUNT, 16'h0000);
    wr(spt_pkg::ADDR_IRQ_MASK, 16'h0001);
    for (int s = 0; s < 4; s++) begin
      wr(spt_pkg::ADDR_CONTROL, 16'h8000 | (16'(s) << 4));
      wr(spt_pkg::ADDR_IRQ_STATUS, 16'h0001);
      wait_irq(ta);
      rd(spt_pkg::ADDR_COUNT, d);
      `CHK("count after wrap", 16'h0000, d)
      wr(spt_pkg::ADDR_IRQ_STATUS, 16'h0001);
      @(negedge core_clk);
      `CHK("irq cleared", 1'b0, irq)
      wait_irq(tb);
      `CHK("wrap interval", 4 * ratio[s] * 2, tb - ta)
    end
    rd(spt_pkg::ADDR_IRQ_STATUS, d);
    `CHK("flag sticky", 16'h0001, d)
    wr(spt_pkg::ADDR_IRQ_MASK, 16'h0000);
    @(negedge core_clk);
    `CHK("irq masked", 1'b0, irq)
    wr(spt_pkg::ADDR_IRQ_MASK, 16'h0001);
    @(negedge core_clk);
    `CHK("irq unmasked", 1'b1, irq)
    wr(spt_pkg::ADDR_CONTROL, 16'h0000);
    wr(spt_pkg::ADDR_IRQ_STATUS, 16'h0001);
    wr(spt_pkg::ADDR_PERIOD, 16'hFFFF);
    wr(spt_pkg::ADDR_CONTROL, 16'hA000);
    cpu_idle <= 1'b1;
    span(d);
    `CHK("idle frozen", 16'h0000, d)
    wr(spt_pkg::ADDR_CONTROL, 16'h8000);
    span(d);
    `CHK("idle running", 16'h000A, d)
    cpu_idle <= 1'b0;
    cpu_sleep <= 1'b1;
    span(d);
    `CHK("sleep frozen", 16'h0000, d)
    burst(16'h8002, 8'h05, 8'h04);
    `CHK("async in sleep", 16'h0005, d)
    cpu_sleep <= 1'b0;
    cpu_idle <= 1'b1;
    burst(16'hA002, 8'h03, 8'h04);
    `CHK("async idle stop", 16'h0000, d)
    cpu_idle <= 1'b0;
    burst(16'h8006, 8'h05, 8'h04);
    `CHK("sync count", 16'h0005, d)
    burst(16'h8016, 8'h10, 8'h04);
    `CHK("sync prescaled", 16'h0002, d)
    wr(spt_pkg::ADDR_IRQ_STATUS, 16'h0001);
    burst(16'h8040, 8'h01, 8'h28);
    `CHK("gated count", 16'h000A, d)
    `CHK("gate fall irq", 1'b1, irq)
    reset_n <= 1'b0;
    @(negedge core_clk);
    `CHK("irq in second reset", 1'b0, irq)
    @(posedge core_clk);
    reset_n <= 1'b1;
    rd(spt_pkg::ADDR_COUNT, d);
    `CHK("count after reset", 16'h0000, d)
    tally_and_finish();
  end
endmodule
